// ### hw/ras_pkg.sv
/*
 * Constants, register map and state encoding for the remote alarm supervisor.
 * Assumes a single 25 MHz system clock and a plain strobe-based register port.
 */
package ras_pkg;

    // alarm vector size and layout
    localparam int NUM_ALARMS = 14;
    localparam int NUM_EXT = 4;
    localparam int IDX_PSU = 0;
    localparam int IDX_AMP = 1;
    localparam int IDX_OPT_RX = 2;
    localparam int IDX_OPT_TX = 3;
    localparam int IDX_PWR28 = 4;
    localparam int IDX_TEMP = 5;
    localparam int IDX_FAN = 6;
    localparam int IDX_TWI = 7;
    localparam int IDX_AMP_PD = 8;
    localparam int IDX_LEVEL_CTRL = 9;
    localparam int IDX_EXT0 = 10;

    // alarms caused outside the unit (orange) and by the unit itself (red)
    localparam logic [NUM_ALARMS-1:0] ORANGE_MASK = 14'h3E04;
    localparam logic [NUM_ALARMS-1:0] RED_MASK = 14'h01FB;

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_EVENT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_ACK = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_LED = 8'h18;

    // reset values
    localparam logic [NUM_ALARMS-1:0] MASK_RESET = 14'h0000;
    localparam logic [NUM_EXT-1:0] POLARITY_RESET = 4'h0;

    // led field positions in the led register
    localparam int LED_GREEN_BIT = 0;
    localparam int LED_ORANGE_BIT = 1;
    localparam int LED_RED_BIT = 2;

    // message port
    localparam int MSG_ID_W = 4;

    // re-arm interval
    localparam int CLK_HZ = 25_000_000;
    localparam int REARM_TIME_MS = 5000;
    localparam int REARM_CYCLES = REARM_TIME_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 27;

    // per-alarm message state
    typedef enum logic [2:0]
    {
        RAS_ARMED = 3'b001,
        RAS_WAIT_ACK = 3'b010,
        RAS_SENT = 3'b100
    } ras_state_t;

endpackage

// ### hw/ras_top.sv
/*
 * Remote alarm supervisor: collects built-in-test and external contact alarms,
 * raises one message per acknowledged alarm with a re-arm interval, drives the
 * status led and the alarm outputs, and offers a small register file.
 * Assumes all alarm inputs are synchronous to clk and that firmware reads the
 * pending register and acknowledges alarms through the ack register.
 */
// The register addresses and strobed register access are this design's own decisions.
// How it works
// R1: raise alarm for failing supply, amplifier, optics
// R2: all present alarms readable by software
// R3: acknowledged alarm sends exactly one message
// R4: no resend while persisting or after clearing
// R5: resend only after five-second absence
// R6: green led when no alarm present
// R7: external, rx optical, level alarms light orange
// R8: unit-internal alarms light red
// R9: alarm output low idle, high active
// R10: unconnected external input reads high
// R11: external input polarity selectable by software
// R12: external device closes contact to ground
// R13: polarised external inputs reported as alarms
// R14: red beats orange beats green
// R15: absence counter cleared when alarm reappears
`timescale 1ns/1ps
`default_nettype none

module ras_top
#(
    parameter int REARM_CYCLES = ras_pkg::REARM_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // built-in-test alarm sources
    input wire logic psu_fail,
    input wire logic amp_fail,
    input wire logic opt_rx_fail,
    input wire logic opt_tx_fail,
    input wire logic pwr28_fail,
    input wire logic over_temp,
    input wire logic fan_fail,
    input wire logic twi_fail,
    input wire logic amp_power_down,
    input wire logic level_control_alarm,
    // external alarm contacts, pulled high when open
    input wire logic [ras_pkg::NUM_EXT-1:0] ext_alarm_in,
    // register port
    input wire logic [ras_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ras_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [ras_pkg::DATA_W-1:0] reg_rdata,
    // messages to the master unit
    output logic msg_valid,
    output logic [ras_pkg::MSG_ID_W-1:0] msg_id,
    // local indication
    output logic led_green,
    output logic led_orange,
    output logic led_red,
    output logic [ras_pkg::NUM_ALARMS-1:0] alarm_out,
    // interrupt
    output logic irq
);

    localparam int NA = ras_pkg::NUM_ALARMS;
    localparam int NE = ras_pkg::NUM_EXT;
    localparam int CW = ras_pkg::CNT_W;
    localparam int DW = ras_pkg::DATA_W;
    localparam logic [CW-1:0] REARM_LAST = CW'(REARM_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // lowest set bit of a vector, used to serialise messages
    function automatic logic [ras_pkg::MSG_ID_W-1:0] first_set(input logic [NA-1:0] v);
        logic [ras_pkg::MSG_ID_W-1:0] idx;
        idx = '0;
        for (int k = NA - 1; k >= 0; k--)
        begin
            if (v[k])
                idx = ras_pkg::MSG_ID_W'(k);
        end
        return idx;
    endfunction

    // register address compare, shared by read and write decode
    function automatic logic hit(input logic [ras_pkg::ADDR_W-1:0] a,
                                 input logic [ras_pkg::ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // reset synchroniser

    logic rst_meta_q;
    logic rst_sync_q;

    // release is synchronous so all flops leave reset on the same edge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    wire logic rst_n = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // alarm gathering

    logic [NE-1:0] polarity_q;
    logic [NE-1:0] ext_active;
    logic [NA-1:0] live;

    // polarity bit 1 means the input alarms when high; reset value 0 means an
    // open contact (pulled high) is quiet and a contact closed to ground alarms
    assign ext_active = ~(ext_alarm_in ^ polarity_q); // R10 R11 R12

    always_comb
    begin
        live = '0;
        live[ras_pkg::IDX_PSU] = psu_fail; // R1
        live[ras_pkg::IDX_AMP] = amp_fail; // R1
        live[ras_pkg::IDX_OPT_RX] = opt_rx_fail; // R1
        live[ras_pkg::IDX_OPT_TX] = opt_tx_fail; // R1
        live[ras_pkg::IDX_PWR28] = pwr28_fail;
        live[ras_pkg::IDX_TEMP] = over_temp;
        live[ras_pkg::IDX_FAN] = fan_fail;
        live[ras_pkg::IDX_TWI] = twi_fail;
        live[ras_pkg::IDX_AMP_PD] = amp_power_down;
        live[ras_pkg::IDX_LEVEL_CTRL] = level_control_alarm;
        live[ras_pkg::IDX_EXT0 +: NE] = ext_active; // R13
    end

    ////////////////////////////////////////////////////////////////////////////
    // register write decode

    logic wr_mask;
    logic wr_pol;
    logic wr_ack;
    logic rd_event;
    logic [NA-1:0] ack_bits;

    assign wr_mask = reg_we && hit(reg_addr, ras_pkg::OFS_MASK);
    assign wr_pol = reg_we && hit(reg_addr, ras_pkg::OFS_POLARITY);
    assign wr_ack = reg_we && hit(reg_addr, ras_pkg::OFS_ACK);
    assign rd_event = reg_re && hit(reg_addr, ras_pkg::OFS_EVENT);
    assign ack_bits = wr_ack ? reg_wdata[NA-1:0] : '0;

    logic [NA-1:0] mask_q;

    // interrupt mask
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= ras_pkg::MASK_RESET;
        else if (wr_mask)
            mask_q <= reg_wdata[NA-1:0];
    end

    // external input polarity, written by master unit software
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            polarity_q <= ras_pkg::POLARITY_RESET;
        else if (wr_pol)
            polarity_q <= reg_wdata[NE-1:0]; // R11
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-alarm message sequencing

    logic [NA-1:0] wait_ack;
    logic [NA-1:0] new_alarm;
    logic [NA-1:0] send_set;
    logic [NA-1:0] send_q;
    logic [NA-1:0] send_grant;

    for (genvar i = 0; i < NA; i++)
    begin : g_alarm
        ras_pkg::ras_state_t state_q;
        logic [CW-1:0] absent_q;

        // armed -> wait for firmware ack -> sent (silenced) -> re-armed once
        // the alarm has stayed away for the full interval after the ack
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                state_q <= ras_pkg::RAS_ARMED;
            else
            begin
                case (state_q)
                    ras_pkg::RAS_ARMED:
                        if (live[i])
                            state_q <= ras_pkg::RAS_WAIT_ACK;
                    ras_pkg::RAS_WAIT_ACK:
                        if (ack_bits[i])
                            state_q <= ras_pkg::RAS_SENT; // R3
                    ras_pkg::RAS_SENT:
                    begin
                        // persisting or cleared alarm stays silent here
                        if (!live[i] && absent_q == REARM_LAST)
                            state_q <= ras_pkg::RAS_ARMED; // R4 R5
                    end
                    default:
                        state_q <= ras_pkg::RAS_ARMED;
                endcase
            end
        end

        // absence timer runs only after the ack, restarts on any reappearance
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                absent_q <= '0;
            else if (state_q != ras_pkg::RAS_SENT || live[i])
                absent_q <= '0; // R15
            else if (absent_q != REARM_LAST)
                absent_q <= absent_q + 1'b1; // R5
        end

        assign wait_ack[i] = state_q == ras_pkg::RAS_WAIT_ACK;
        assign new_alarm[i] = state_q == ras_pkg::RAS_ARMED && live[i];
        assign send_set[i] = wait_ack[i] && ack_bits[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    // message serialiser

    // several acks may land together; one message per cycle, lowest id first
    assign send_grant = (|send_q) ? (NA'(1) << first_set(send_q)) : '0;

    // new request wins over a grant of the same bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            send_q <= '0;
        else
            send_q <= (send_q & ~send_grant) | send_set; // R3
    end

    // one-cycle message strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_valid <= 1'b0;
            msg_id <= '0;
        end
        else
        begin
            msg_valid <= |send_q; // R3
            msg_id <= first_set(send_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event flags and interrupt

    logic [NA-1:0] event_q;

    // read clears; an alarm arriving in the clearing cycle still sets
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            event_q <= '0;
        else
            event_q <= (rd_event ? '0 : event_q) | new_alarm;
    end

    // level interrupt, one cycle behind the flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(event_q & mask_q);
    end

    ////////////////////////////////////////////////////////////////////////////
    // local indication

    // red over orange over green
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            led_green <= 1'b1;
            led_orange <= 1'b0;
            led_red <= 1'b0;
        end
        else
        begin
            led_red <= |(live & ras_pkg::RED_MASK); // R8 R14
            led_orange <= !(|(live & ras_pkg::RED_MASK))
                          && |(live & ras_pkg::ORANGE_MASK); // R7 R14
            led_green <= !(|live); // R6 R14
        end
    end

    // open-collector alarm outputs follow the live alarms
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            alarm_out <= '0;
        else
            alarm_out <= live; // R9
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read

    logic [DW-1:0] rdata_d;

    // unmapped addresses read as zero
    always_comb
    begin
        rdata_d = '0;
        if (hit(reg_addr, ras_pkg::OFS_LIVE))
            rdata_d[NA-1:0] = live; // R2
        else if (hit(reg_addr, ras_pkg::OFS_EVENT))
            rdata_d[NA-1:0] = event_q;
        else if (hit(reg_addr, ras_pkg::OFS_MASK))
            rdata_d[NA-1:0] = mask_q;
        else if (hit(reg_addr, ras_pkg::OFS_POLARITY))
            rdata_d[NE-1:0] = polarity_q;
        else if (hit(reg_addr, ras_pkg::OFS_PENDING))
            rdata_d[NA-1:0] = wait_ack; // R2
        else if (hit(reg_addr, ras_pkg::OFS_LED))
        begin
            rdata_d[ras_pkg::LED_GREEN_BIT] = led_green;
            rdata_d[ras_pkg::LED_ORANGE_BIT] = led_orange;
            rdata_d[ras_pkg::LED_RED_BIT] = led_red;
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_re ? rdata_d : '0;
    end

endmodule

`default_nettype wire

// ### test/ras_props.sv
/*
 * ras_props: port-level checker for ras_top.
 * Assumes it is bound to ras_top; polarity is shadowed from register writes.
 */
`timescale 1ns/1ps
`default_nettype none

module ras_props
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // alarm sources
    input wire logic psu_fail,
    input wire logic amp_fail,
    input wire logic opt_rx_fail,
    input wire logic opt_tx_fail,
    input wire logic pwr28_fail,
    input wire logic over_temp,
    input wire logic fan_fail,
    input wire logic twi_fail,
    input wire logic amp_power_down,
    input wire logic level_control_alarm,
    input wire logic [3:0] ext_alarm_in,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [31:0] reg_rdata,
    // outputs
    input wire logic msg_valid,
    input wire logic [3:0] msg_id,
    input wire logic led_green,
    input wire logic led_orange,
    input wire logic led_red,
    input wire logic [13:0] alarm_out,
    input wire logic irq
);
    logic [3:0] pol_q;
    logic [1:0] up_q;
    logic [4:0] ack_age_q;
    logic [13:0] live;
    logic ok;

    // internal reset lags two edges, so checks wait for the third
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            up_q <= 2'h0;
        else if (up_q != 2'h3)
            up_q <= up_q + 2'h1;
    end

    // polarity is not visible at the ports, so it is shadowed here;
    // the design already takes writes at the third edge after release
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pol_q <= 4'h0;
        else if (up_q[1] && reg_we && reg_addr == ras_pkg::OFS_POLARITY)
            pol_q <= reg_wdata[3:0];
    end

    // cycles since the last acknowledge write, saturating
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ack_age_q <= 5'h1F;
        else if (reg_we && reg_addr == ras_pkg::OFS_ACK)
            ack_age_q <= 5'h00;
        else if (ack_age_q != 5'h1F)
            ack_age_q <= ack_age_q + 5'h01;
    end

    // expected live vector built from the pins
    assign ok = (up_q == 2'h3);
    assign live = {~(ext_alarm_in ^ pol_q), level_control_alarm, amp_power_down, twi_fail,
        fan_fail, over_temp, pwr28_fail, opt_tx_fail, opt_rx_fail, amp_fail, psu_fail};

    ////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_led_one_hot: assert property (ok |-> $onehot({led_green, led_orange, led_red}))
        else $error("led colours not one-hot");
    a_red_first: assert property (ok && |(live & ras_pkg::RED_MASK) |=> led_red)
        else $error("red led missing");
    a_orange_next: assert property (ok && !(|(live & ras_pkg::RED_MASK))
        && |(live & ras_pkg::ORANGE_MASK) |=> led_orange) else $error("orange led missing");
    a_green_idle: assert property (ok && live == 14'h0000 |=> led_green)
        else $error("green led missing");
    a_alarm_copy: assert property (ok |=> alarm_out == $past(live))
        else $error("alarm outputs differ from sources");
    a_rdata_quiet: assert property (ok && !reg_re |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    a_msg_id_range: assert property (msg_valid |-> msg_id < 4'hE)
        else $error("message index out of range");
    a_msg_after_ack: assert property (msg_valid |-> ack_age_q < 5'h0F)
        else $error("message without recent acknowledge");
    a_msg_no_repeat: assert property (msg_valid && $past(msg_valid) |->
        msg_id != $past(msg_id)) else $error("message repeated");

    // main scenarios reached
    c_msg: cover property (msg_valid);
    c_red: cover property (led_red);
    c_orange: cover property (led_orange);
    c_irq: cover property (irq);
endmodule

bind ras_top ras_props chk_u (.*);

`default_nettype wire

// ### test/ras_contacts.sv
/*
 * ras_contacts: monitored external equipment on the alarm input pins.
 * Assumes a pull-up per pin, so an open contact reads high.
 */
`timescale 1ns/1ps
`default_nettype none

module ras_contacts
(
    // contact state, 1 = closed
    input wire logic [3:0] closed,
    // pin levels seen by the supervisor
    output logic [3:0] level
);
    // closed shorts to common ground, open floats to the pull-up
    assign level = ~closed;
endmodule

`default_nettype wire

// ### test/test_remote_alarm_supervisor.sv
/*
 * test_remote_alarm_supervisor: messages, re-arm, polarity, interrupt, leds
 * and random alarm traffic for ras_top.
 * Assumes the checker is bound in and the re-arm count is shortened.
 */
`timescale 1ns/1ps
`default_nettype none

module test_remote_alarm_supervisor;
    localparam int REARM = 20;
    logic clk = 1'b0;
    logic nrst, psu_fail, amp_fail, opt_rx_fail, opt_tx_fail, pwr28_fail;
    logic over_temp, fan_fail, twi_fail, amp_power_down, level_control_alarm;
    logic reg_we, reg_re, msg_valid, led_green, led_orange, led_red, irq, re_d;
    logic [3:0] ext_alarm_in, closed, msg_id;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed;
    logic [13:0] alarm_out;
    logic [31:0] rd_q[$];
    logic [3:0] msg_q[$];
    int fail_count, n_tests;

    ras_top #(.REARM_CYCLES(REARM)) dut_u (.*);
    ras_contacts peer_u (.closed(closed), .level(ext_alarm_in));

    always #20 clk = ~clk;

    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task summarize;
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task set_src(input logic [9:0] v);
        {level_control_alarm, amp_power_down, twi_fail, fan_fail, over_temp,
            pwr28_fail, opt_tx_fail, opt_rx_fail, amp_fail, psu_fail} <= v;
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
    endtask

    // bounded wait until every noted result has been seen
    task drain;
        for (int i = 0; i < 40 && rd_q.size() + msg_q.size() != 0; i++)
            @(posedge clk);
        if (rd_q.size() + msg_q.size() != 0)
        begin
            fail_count++;
            summarize();
        end
    endtask

    // results are matched against the oldest note as they appear
    always @(posedge clk)
    begin
        re_d <= reg_re;
        if (re_d === 1'b1)
            check("reg_rdata", reg_rdata, rd_q.pop_front());
        if (msg_valid === 1'b1)
            check("msg_id", msg_id, msg_q.size() ? msg_q.pop_front() : 32'hFF);
    end

    // a hang counts as a mismatch
    initial
    begin
        #4000000;
        fail_count++;
        summarize();
    end

    initial
    begin
        {nrst, reg_we, reg_re, reg_addr, reg_wdata} = '0;
        closed = 4'h0;
        seed = 32'h0000_0032;
        fail_count = 0;
        n_tests = 0;
        set_src(10'h000);
        tick(16);
        nrst <= 1'b1;
        tick(3);
        check("led_green", led_green, 1'b1);
        rd(ras_pkg::OFS_MASK, 32'h0);
        rd(ras_pkg::OFS_POLARITY, 32'h0);
        rd(8'hFC, 32'h0);
        rd(ras_pkg::OFS_LED, 32'h1);
        // amplifier alarm: unmasked interrupt, one message after ack
        wr(ras_pkg::OFS_MASK, 32'h2);
        set_src(10'h002);
        tick(3);
        check("irq", irq, 1'b1);
        rd(ras_pkg::OFS_PENDING, 32'h2);
        rd(ras_pkg::OFS_EVENT, 32'h2);
        tick(2);
        check("irq", irq, 1'b0);
        wr(ras_pkg::OFS_ACK, 32'h1);
        msg_q.push_back(4'h1);
        wr(ras_pkg::OFS_ACK, 32'h2);
        drain();
        // persisting, then short dips: no new message
        tick(5);
        set_src(10'h000);
        tick(REARM / 2);
        set_src(10'h002);
        tick(2);
        set_src(10'h000);
        tick(REARM - 1); // one cycle short of the interval
        set_src(10'h002);
        tick(3);
        rd(ras_pkg::OFS_PENDING, 32'h0);
        // an absence of exactly the interval re-arms the channel
        set_src(10'h000);
        tick(REARM);
        set_src(10'h002);
        tick(3);
        rd(ras_pkg::OFS_PENDING, 32'h2);
        msg_q.push_back(4'h1);
        wr(ras_pkg::OFS_ACK, 32'h2);
        rd(ras_pkg::OFS_EVENT, 32'h2);
        drain();
        // open contact made active by polarity, plus optical receive
        set_src(10'h004);
        wr(ras_pkg::OFS_POLARITY, 32'h1);
        tick(3);
        check("irq", irq, 1'b0);
        rd(ras_pkg::OFS_LIVE, 32'h404);
        rd(ras_pkg::OFS_LED, 32'h2);
        rd(ras_pkg::OFS_PENDING, 32'h404);
        msg_q.push_back(4'h2);
        msg_q.push_back(4'hA);
        wr(ras_pkg::OFS_ACK, 32'h404);
        drain();
        // temperature on top: red wins
        set_src(10'h024);
        tick(3);
        rd(ras_pkg::OFS_LED, 32'h4);
        check("alarm_out", alarm_out, 14'h0424);
        // random sources and contacts, judged by the checker
        repeat (300)
        begin
            seed = xs(seed);
            set_src(seed[9:0]);
            closed <= seed[13:10];
            @(posedge clk);
        end
        drain();
        summarize();
    end
endmodule

`default_nettype wire
